// file: design/cacc_top.sv
// Cell acquisition channel configuration and result storage
// Behaviour
// - Flex on plus scan flag: detach top cell from supply, wait 30us.
// - Scan flag acts only on alternate-path acquisitions.
// - Raise supply-mux fault alert when the switch fails in flex setup.
// - Alert stays suppressed until software clears the alert-reset flag.
// - Fourteen differential cell channels from fifteen inputs.
// - Per-cell enables pick channels; one bit picks input path.
// - Conversions accumulate and average into a 14-bit channel result.
// - Result stored left-justified in 16 bits, two low bits zero.
// - Channels not enabled keep their previous results.
// - Cell codes are unsigned, 5V/16384 per code.
// - Polarity bit set makes that channel convert bipolar.
// - Pack input path open whenever no acquisition runs.
// - Pack enable measures pack voltage into a 14-bit field.
// - Six aux ports measured when enabled; reference bit picks ratiometric.
// - GPIO enable overrides the aux enable of a port.
// - Ratiometric port drives supply on the thermistor bias pin.
// - Top-cell codes 0x0-0x7 and 0xF mean off, the reset default.
// - Disagreeing redundant flex enables or top-cell selects fall back to defaults.
`timescale 1ns/1ns
`default_nettype none
module cacc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             conv_req_o,
  output logic [4:0]       conv_chan_o,
  output logic             conv_bipolar_o,
  output logic             conv_alt_path_o,
  output logic             conv_ratio_o,
  input  wire logic        conv_done_i,
  input  wire logic [11:0] conv_data_i,
  input  wire logic        supply_mux_fault_i,
  output logic             top_cell_detach_o,
  output logic [3:0]       top_cell_applied_o,
  output logic [3:0]       top_block_select_o,
  output logic             pack_path_close_o,
  output logic             thermistor_bias_output_o,
  output logic [5:0]       port_gpio_enables_o,
  output logic             supply_mux_fault_alert_o
);
  import cacc_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  typedef struct packed {
    cacc_state_t            st;
    logic [13:0]            cell_en;
    logic                   pack_en;
    logic [5:0]             aux_en;
    logic                   path_alt;
    logic                   flex_scan;
    logic [3:0]             top_a;
    logic [3:0]             top_b;
    logic                   flex_a;
    logic                   flex_b;
    logic [3:0]             top_blk;
    logic [5:0]             aux_ref;
    logic [5:0]             gpio_en;
    logic [13:0]            polar;
    logic                   alert;
    logic                   alert_rst;
    logic [4:0]             ch;
    logic [20:0]            mask;
    logic [1:0]             nconv;
    logic [13:0]            acc;
    logic [9:0]             settle;
    logic [13:0][13:0]      cell_res;
    logic [13:0]            pack_res;
    logic [5:0][13:0]       aux_res;
    logic                   ack;
    logic [31:0]            dat;
    logic                   req;
    logic                   bip;
    logic                   ratio;
    logic                   detach;
    logic                   pclose;
    logic                   bias;
    logic [3:0]             top_app;
  } cacc_regs_t;

  cacc_regs_t  r_reg;
  cacc_regs_t  r_next;
  logic        fault_s;
  logic        flex_ok;
  logic [3:0]  top_code;
  logic        top_valid;
  logic [4:0]  top_ch;
  logic [5:0]  widx;
  logic        wr;
  logic        rd;
  logic [20:0] rem;
  logic [4:0]  nxt;
  logic [13:0] sample;
  logic [3:0]  cidx;
  logic [2:0]  aidx;
  logic [9:0]  det_cnt;

  // ****************************************
  // Fault pin synchroniser
  // ****************************************
  cacc_sync u_fault_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (supply_mux_fault_i),
    .q_o   (fault_s)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.req = 1'b0;
    widx = wb_adr_i[7:2];
    wr = wb_cyc_i && wb_stb_i && !r_reg.ack && wb_we_i;
    rd = wb_cyc_i && wb_stb_i && !r_reg.ack && !wb_we_i;
    cidx = 4'(widx - IDX_CELL0);
    aidx = 3'(widx - IDX_AUX0);
    // Redundant copies must agree, else defaults apply
    flex_ok = (r_reg.flex_a == r_reg.flex_b) ? r_reg.flex_a : FLEX_RST;
    top_code = (r_reg.top_a == r_reg.top_b) ? r_reg.top_a : TOP_OFF;
    top_valid = (top_code >= TOP_MIN) && (top_code != TOP_BAD);
    top_ch = 5'(top_code - 4'h1);
    r_next.top_app = top_valid ? top_code : TOP_OFF;
    // Bias follows any enabled ratiometric port
    r_next.bias = |(r_reg.aux_en & ~r_reg.gpio_en & ~r_reg.aux_ref);
    // Sign handling of the incoming conversion
    if (r_reg.ch < CH_PACK && r_reg.polar[r_reg.ch[3:0]]) begin
      sample = {{2{conv_data_i[11]}}, conv_data_i};
    end else begin
      sample = {2'h0, conv_data_i};
    end
    // Bus access: ack one cycle after the request, dropped the next
    if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
      r_next.ack = 1'b1;
      r_next.dat = 32'h0;
    end
    if (wr && wb_sel_i[0]) begin
      case (widx)
        IDX_MEAS1:   r_next.cell_en[7:0] = wb_dat_i[7:0];
        IDX_MEAS2:   r_next.aux_en = wb_dat_i[5:0];
        IDX_SCAN:    r_next.path_alt = wb_dat_i[SCAN_PATH];
        IDX_PACKCFG: r_next.top_a = wb_dat_i[PCFG_TOPA +: 4];
        IDX_AUXREF:  r_next.aux_ref = wb_dat_i[5:0];
        IDX_GPIOCFG: r_next.gpio_en = wb_dat_i[5:0];
        IDX_POLAR:   r_next.polar[7:0] = wb_dat_i[7:0];
        IDX_ALERT: begin
          r_next.alert_rst = wb_dat_i[ALRT_RST];
          if (wb_dat_i[ALRT_FAULT]) begin
            r_next.alert = 1'b0;
          end
        end
        default: ;
      endcase
      if (widx == IDX_SCAN) begin
        r_next.flex_scan = wb_dat_i[SCAN_FLEX];
      end
      if (widx == IDX_PACKCFG) begin
        r_next.top_b = wb_dat_i[PCFG_TOPB +: 4];
      end
    end
    if (wr && wb_sel_i[1]) begin
      case (widx)
        IDX_MEAS1: begin
          r_next.cell_en[13:8] = wb_dat_i[13:8];
          r_next.pack_en = wb_dat_i[MEAS1_PACK];
        end
        IDX_PACKCFG: begin
          r_next.flex_a = wb_dat_i[PCFG_FLEXA];
          r_next.flex_b = wb_dat_i[PCFG_FLEXB];
          r_next.top_blk = wb_dat_i[PCFG_TOPBLK +: 4];
        end
        IDX_POLAR:   r_next.polar[13:8] = wb_dat_i[13:8];
        default: ;
      endcase
    end
    if (rd) begin
      case (widx)
        IDX_MEAS1:   r_next.dat = {17'h0, r_reg.pack_en, r_reg.cell_en};
        IDX_MEAS2:   r_next.dat = {26'h0, r_reg.aux_en};
        IDX_SCAN: begin
          r_next.dat = {23'h0, r_reg.st != ST_IDLE, 5'h0,
                        r_reg.flex_scan, r_reg.path_alt, 1'b0};
        end
        IDX_PACKCFG: begin
          r_next.dat = {16'h0, r_reg.top_blk, 2'h0, r_reg.flex_b,
                        r_reg.flex_a, r_reg.top_b, r_reg.top_a};
        end
        IDX_AUXREF:  r_next.dat = {26'h0, r_reg.aux_ref};
        IDX_GPIOCFG: r_next.dat = {26'h0, r_reg.gpio_en};
        IDX_POLAR:   r_next.dat = {18'h0, r_reg.polar};
        IDX_ALERT:   r_next.dat = {30'h0, r_reg.alert_rst, r_reg.alert};
        IDX_PACKRES: r_next.dat = {16'h0, r_reg.pack_res, 2'h0};
        default: begin
          if (widx >= IDX_CELL0 && widx < IDX_CELL0 + 6'(N_CELL)) begin
            r_next.dat = {16'h0, r_reg.cell_res[cidx], 2'h0};
          end else if (widx >= IDX_AUX0 && widx < IDX_AUX0 + 6'(N_AUX)) begin
            r_next.dat = {16'h0, r_reg.aux_res[aidx], 2'h0};
          end
        end
      endcase
    end
    // Sticky alert, gated after power-up; set wins over clear
    if (flex_ok && fault_s && !r_reg.alert_rst) begin
      r_next.alert = 1'b1;
    end
    // Next enabled channel above the current one
    rem = r_reg.mask;
    rem[r_reg.ch] = 1'b0;
    nxt = 5'h0;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (rem[i]) begin
        nxt = 5'(i);
      end
    end
    // Acquisition sequencer
    case (r_reg.st)
      ST_IDLE: begin
        r_next.pclose = 1'b0;
        if (wr && wb_sel_i[0] && widx == IDX_SCAN && wb_dat_i[SCAN_START]) begin
          // Channels latched at start; GPIO ports dropped
          r_next.mask = {r_reg.aux_en & ~r_reg.gpio_en, r_reg.pack_en,
                         r_reg.cell_en};
          if (|r_next.mask) begin
            r_next.ch = 5'h0;
            for (int i = N_CH - 1; i >= 0; i--) begin
              if (r_next.mask[i]) begin
                r_next.ch = 5'(i);
              end
            end
            r_next.pclose = r_reg.pack_en;
            r_next.st = ST_SEL;
          end
        end
      end
      ST_SEL: begin
        r_next.acc = 14'h0;
        r_next.nconv = 2'h0;
        r_next.bip = (r_reg.ch < CH_PACK) && r_reg.polar[r_reg.ch[3:0]];
        r_next.ratio = (r_reg.ch >= CH_AUX0) &&
                       !r_reg.aux_ref[3'(r_reg.ch - CH_AUX0)];
        if (flex_ok && r_reg.flex_scan && r_reg.path_alt && top_valid &&
            r_reg.ch == top_ch) begin
          r_next.detach = 1'b1;
          r_next.settle = 10'(SETTLE_CYC - 1);
          r_next.st = ST_SETTLE;
        end else begin
          r_next.st = ST_REQ;
        end
      end
      ST_SETTLE: begin
        if (r_reg.settle == 10'h0) begin
          r_next.st = ST_REQ;
        end else begin
          r_next.settle = r_reg.settle - 10'h1;
        end
      end
      ST_REQ: begin
        r_next.req = 1'b1;
        r_next.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (conv_done_i) begin
          r_next.acc = r_reg.acc + sample;
          r_next.nconv = r_reg.nconv + 2'h1;
          r_next.st = (r_reg.nconv == CONV_LAST) ? ST_STORE : ST_REQ;
        end
      end
      ST_STORE: begin
        // Only the current channel's result is written
        if (r_reg.ch < CH_PACK) begin
          r_next.cell_res[r_reg.ch[3:0]] = r_reg.acc;
        end else if (r_reg.ch == CH_PACK) begin
          r_next.pack_res = r_reg.acc;
        end else begin
          r_next.aux_res[3'(r_reg.ch - CH_AUX0)] = r_reg.acc;
        end
        r_next.detach = 1'b0;
        r_next.mask = rem;
        if (|rem) begin
          r_next.ch = nxt;
          r_next.st = ST_SEL;
        end else begin
          r_next.pclose = 1'b0;
          r_next.st = ST_IDLE;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
  end
  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.top_blk <= TOPBLK_RST;
      r_reg.alert_rst <= ALRST_RST;
    end else begin
      r_reg <= r_next;
    end
  end
  // Outputs straight from the state register
  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign conv_req_o = r_reg.req;
  assign conv_chan_o = r_reg.ch;
  assign conv_bipolar_o = r_reg.bip;
  assign conv_alt_path_o = r_reg.path_alt;
  assign conv_ratio_o = r_reg.ratio;
  assign top_cell_detach_o = r_reg.detach;
  assign top_cell_applied_o = r_reg.top_app;
  assign top_block_select_o = r_reg.top_blk;
  assign pack_path_close_o = r_reg.pclose;
  assign thermistor_bias_output_o = r_reg.bias;
  assign port_gpio_enables_o = r_reg.gpio_en;
  assign supply_mux_fault_alert_o = r_reg.alert;
  // ****************************************
  // Checks
  // ****************************************
  // Cycles spent detached before a request
  always_ff @(posedge clk_i) begin
    if (rst_i || !r_reg.detach) begin
      det_cnt <= 10'h0;
    end else if (det_cnt != 10'h3FF) begin
      det_cnt <= det_cnt + 10'h1;
    end
  end
  a_settle_min: assert property (r_reg.req && r_reg.detach |-> det_cnt >= 10'(SETTLE_CYC))
    else $error("top cell converted before settling");
  a_primary_path: assert property (!r_reg.path_alt && r_reg.st == ST_SEL |=> !r_reg.detach)
    else $error("primary path detached top cell");
  a_alert_gated: assert property ($rose(r_reg.alert) |-> !$past(r_reg.alert_rst))
    else $error("alert rose while gated");
  a_alert_raise: assert property (flex_ok && fault_s && !r_reg.alert_rst |=> r_reg.alert)
    else $error("fault not flagged");
  a_pack_idle_open: assert property (r_reg.st == ST_IDLE && $past(r_reg.st) == ST_IDLE
                                     |-> !r_reg.pclose)
    else $error("pack path closed while idle");
  a_idle_results_keep: assert property (r_reg.st != ST_STORE |=> $stable(r_reg.cell_res))
    else $error("result changed outside store");
  a_result_low_zero: assert property (r_reg.ack && widx >= IDX_CELL0
                                      && widx <= IDX_PACKRES |-> r_reg.dat[1:0] == 2'h0)
    else $error("result low bits not zero");
  a_gpio_skips_aux: assert property (r_reg.req && r_reg.ch >= CH_AUX0
                                     |-> !r_reg.gpio_en[3'(r_reg.ch - CH_AUX0)])
    else $error("GPIO port was converted");
  a_detach_top_valid: assert property (r_reg.detach |-> top_valid && flex_ok)
    else $error("detach with invalid top cell");
  a_four_conv: assert property (r_reg.st == ST_STORE |-> $past(r_reg.nconv) == CONV_LAST)
    else $error("result stored early");
endmodule
`default_nettype wire

// file: common/cacc_pkg.sv
// Package: register map, field layout, timing and state type of the channel block
package cacc_pkg;

  // ****************************************
  // Register word indices (byte address = 4 x index)
  // ****************************************
  localparam logic [5:0] IDX_MEAS1    = 6'h00;
  localparam logic [5:0] IDX_MEAS2    = 6'h01;
  localparam logic [5:0] IDX_SCAN     = 6'h02;
  localparam logic [5:0] IDX_PACKCFG  = 6'h03;
  localparam logic [5:0] IDX_AUXREF   = 6'h04;
  localparam logic [5:0] IDX_GPIOCFG  = 6'h05;
  localparam logic [5:0] IDX_POLAR    = 6'h06;
  localparam logic [5:0] IDX_ALERT    = 6'h07;
  localparam logic [5:0] IDX_CELL0    = 6'h10;
  localparam logic [5:0] IDX_PACKRES  = 6'h20;
  localparam logic [5:0] IDX_AUX0     = 6'h28;

  // ****************************************
  // Sizes and field positions
  // ****************************************
  localparam int         N_CELL       = 14;
  localparam int         N_AUX        = 6;
  localparam int         N_CH         = 21;
  localparam logic [4:0] CH_PACK      = 5'h0E;
  localparam logic [4:0] CH_AUX0      = 5'h0F;
  localparam int         SCAN_START   = 0;
  localparam int         SCAN_PATH    = 1;
  localparam int         SCAN_FLEX    = 2;
  localparam int         SCAN_BUSY    = 8;
  localparam int         MEAS1_PACK   = 14;
  localparam int         PCFG_TOPA    = 0;
  localparam int         PCFG_TOPB    = 4;
  localparam int         PCFG_FLEXA   = 8;
  localparam int         PCFG_FLEXB   = 9;
  localparam int         PCFG_TOPBLK  = 12;
  localparam int         ALRT_FAULT   = 0;
  localparam int         ALRT_RST     = 1;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [3:0] TOP_OFF      = 4'h0;
  localparam logic [3:0] TOP_MIN      = 4'h8;
  localparam logic [3:0] TOP_BAD      = 4'hF;
  localparam logic [3:0] TOPBLK_RST   = 4'hF;
  localparam logic       FLEX_RST     = 1'b0;
  localparam logic       ALRST_RST    = 1'b1;
  localparam logic [1:0] CONV_LAST    = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_NS       = 50;
  localparam int         SETTLE_NS    = 30000;
  localparam int         SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_SETTLE, ST_REQ, ST_WAIT, ST_STORE} cacc_state_t;

endpackage

// file: design/cacc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module cacc_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed {
    logic [2:0] sh;
    logic       q;
  } cacc_sync_regs_t;

  cacc_sync_regs_t s_reg;
  cacc_sync_regs_t s_next;

  // Shift chain; output moves only when stages two and three agree
  always_comb begin
    s_next = s_reg;
    s_next.sh = {s_reg.sh[1:0], d_i};
    if (s_reg.sh[1] == s_reg.sh[2]) begin
      s_next.q = s_reg.sh[2];
    end
  end

  // Stage registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Output straight from its flip-flop
  assign q_o = s_reg.q;
endmodule
`default_nettype wire

// file: verification/cacc_tb.sv
// Self-checking testbench for the cell acquisition channel block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cacc_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, conv_req_o, conv_bipolar_o, conv_alt_path_o, conv_ratio_o;
  logic [4:0]  conv_chan_o;
  logic        conv_done_i = 1'b0;
  logic [11:0] conv_data_i = 12'h000;
  logic        supply_mux_fault_i = 1'b0;
  logic        top_cell_detach_o, pack_path_close_o, thermistor_bias_output_o;
  logic        supply_mux_fault_alert_o;
  logic [3:0]  top_cell_applied_o, top_block_select_o;
  logic [5:0]  port_gpio_enables_o;
  logic [11:0] samp [0:31];
  logic        bip_seen [0:31];
  logic        ratio_seen [0:31];
  logic        alt_seen, pclose_seen, det_seen;
  logic [1:0]  dly = 2'h0;
  logic [4:0]  ch = 5'h00;
  int          reqs, settle;
  int          n_errors = 0;
  int          checked = 0;

  cacc_top cacc_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_req_o(conv_req_o),
    .conv_chan_o(conv_chan_o), .conv_bipolar_o(conv_bipolar_o),
    .conv_alt_path_o(conv_alt_path_o), .conv_ratio_o(conv_ratio_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .supply_mux_fault_i(supply_mux_fault_i), .top_cell_detach_o(top_cell_detach_o),
    .top_cell_applied_o(top_cell_applied_o), .top_block_select_o(top_block_select_o),
    .pack_path_close_o(pack_path_close_o),
    .thermistor_bias_output_o(thermistor_bias_output_o),
    .port_gpio_enables_o(port_gpio_enables_o),
    .supply_mux_fault_alert_o(supply_mux_fault_alert_o)
  );

  // ****************************************
  // Clock and converter stand-in
  // ****************************************
  // 50 ns clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // Answers each request three cycles later and logs what the request carried
  always @(posedge clk_i) begin
    conv_done_i <= (conv_req_o !== 1'b1 && dly == 2'h1);
    if (top_cell_detach_o === 1'b1) det_seen <= 1'b1;
    if (top_cell_detach_o === 1'b1 && reqs == 0) settle <= settle + 1;
    if (conv_req_o === 1'b1) begin
      dly <= 2'h3;
      ch <= conv_chan_o;
      reqs <= reqs + 1;
      bip_seen[conv_chan_o] <= conv_bipolar_o;
      ratio_seen[conv_chan_o] <= conv_ratio_o;
      if (conv_alt_path_o === 1'b1) alt_seen <= 1'b1;
      if (pack_path_close_o === 1'b1) pclose_seen <= 1'b1;
    end else if (dly != 2'h0) begin
      dly <= dly - 2'h1;
      if (dly == 2'h1) begin
        conv_data_i <= samp[ch];
      end
    end
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    if (n >= 40) begin
      n_errors++;
      $display("MISMATCH bus_ack expected 1 seen none");
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rdchk(input string nm, input logic [5:0] idx, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 32'h0, q);
    chk(nm, e, q);
  endtask

  // Start a scan and poll the busy flag until it clears
  task automatic do_scan(input logic [31:0] ctl);
    logic [31:0] q;
    int n;
    reqs = 0;
    settle = 0;
    alt_seen = 1'b0;
    pclose_seen = 1'b0;
    det_seen = 1'b0;
    wr(IDX_SCAN, ctl | 32'h1);
    n = 0;
    q = 32'h100;
    while (q[SCAN_BUSY] !== 1'b0 && n < 1000) begin
      wb(1'b0, IDX_SCAN, 32'h0, q);
      n++;
    end
    chk("scan_done", 32'h0, 32'(q[SCAN_BUSY]));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("top_applied", 32'h0, 32'(top_cell_applied_o));
    chk("top_block", 32'hF, 32'(top_block_select_o));
    chk("alert_pin", 32'h0, 32'(supply_mux_fault_alert_o));
    rdchk("alert_reg", IDX_ALERT, 32'h2);
    rdchk("unmapped", 6'h3F, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_cells();
    samp[0] = 12'h123;
    samp[13] = 12'hF00;
    samp[14] = 12'h7FF;
    samp[5] = 12'h001;
    wr(IDX_POLAR, 32'h2000);
    wr(IDX_MEAS1, 32'h6001);
    do_scan(32'h0);
    chk("reqs", 32'd12, 32'(reqs));
    rdchk("cell1", IDX_CELL0, 32'h1230);
    rdchk("cell14", IDX_CELL0 + 6'd13, 32'hF000);
    rdchk("pack", IDX_PACKRES, 32'h7FF0);
    rdchk("cell6", IDX_CELL0 + 6'd5, 32'h0);
    chk("bip14", 32'h1, 32'(bip_seen[13]));
    chk("bip1", 32'h0, 32'(bip_seen[0]));
    chk("pack_close", 32'h1, 32'(pclose_seen));
    chk("pack_open", 32'h0, 32'(pack_path_close_o));
    chk("alt", 32'h0, 32'(alt_seen));
    wr(IDX_MEAS1, 32'h0020);
    do_scan(32'h2);
    chk("alt", 32'h1, 32'(alt_seen));
    rdchk("cell6", IDX_CELL0 + 6'd5, 32'h0010);
    rdchk("cell1", IDX_CELL0, 32'h1230);
    chk("pack_close", 32'h0, 32'(pclose_seen));
    $display("test cells done");
  endtask

  task automatic t_aux();
    for (int i = 0; i < N_AUX; i++) samp[15 + i] = 12'h100 + 12'(i);
    wr(IDX_GPIOCFG, 32'h01);
    wr(IDX_AUXREF, 32'h3D);
    wr(IDX_MEAS2, 32'h3F);
    wr(IDX_MEAS1, 32'h0);
    chk("bias", 32'h1, 32'(thermistor_bias_output_o));
    chk("gpio", 32'h01, 32'(port_gpio_enables_o));
    do_scan(32'h0);
    chk("reqs", 32'd20, 32'(reqs));
    chk("ratio1", 32'h1, 32'(ratio_seen[16]));
    chk("ratio2", 32'h0, 32'(ratio_seen[17]));
    rdchk("aux2", IDX_AUX0 + 6'd2, 32'h1020);
    rdchk("aux0", IDX_AUX0, 32'h0);
    wr(IDX_GPIOCFG, 32'h02);
    chk("bias", 32'h0, 32'(thermistor_bias_output_o));
    wr(IDX_MEAS2, 32'h0);
    $display("test aux done");
  endtask

  task automatic t_flex();
    wr(IDX_PACKCFG, 32'hC3EE);
    chk("top_applied", 32'hE, 32'(top_cell_applied_o));
    chk("top_block", 32'hC, 32'(top_block_select_o));
    samp[13] = 12'h400;
    wr(IDX_POLAR, 32'h0);
    wr(IDX_MEAS1, 32'h2000);
    do_scan(32'h4);
    chk("detach", 32'h0, 32'(det_seen));
    do_scan(32'h6);
    chk("detach", 32'h1, 32'(det_seen));
    chk("settle", 32'h1, 32'(settle >= SETTLE_CYC && settle <= SETTLE_CYC + 2));
    chk("detach_end", 32'h0, 32'(top_cell_detach_o));
    rdchk("cell14", IDX_CELL0 + 6'd13, 32'h4000);
    do_scan(32'h2);
    chk("detach", 32'h0, 32'(det_seen));
    wr(IDX_PACKCFG, 32'h3ED);
    chk("top_applied", 32'h0, 32'(top_cell_applied_o));
    wr(IDX_PACKCFG, 32'h1EE);
    do_scan(32'h6);
    chk("detach", 32'h0, 32'(det_seen));
    wr(IDX_PACKCFG, 32'h377);
    chk("top_applied", 32'h0, 32'(top_cell_applied_o));
    wr(IDX_PACKCFG, 32'h3FF);
    chk("top_applied", 32'h0, 32'(top_cell_applied_o));
    wr(IDX_PACKCFG, 32'h388);
    chk("top_applied", 32'h8, 32'(top_cell_applied_o));
    $display("test flex done");
  endtask

  task automatic t_alert();
    wr(IDX_PACKCFG, 32'h3EE);
    supply_mux_fault_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("alert", 32'h0, 32'(supply_mux_fault_alert_o));
    wr(IDX_ALERT, 32'h0);
    repeat (8) @(posedge clk_i);
    chk("alert", 32'h1, 32'(supply_mux_fault_alert_o));
    supply_mux_fault_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("alert_sticky", 32'h1, 32'(supply_mux_fault_alert_o));
    wr(IDX_ALERT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("alert", 32'h0, 32'(supply_mux_fault_alert_o));
    rdchk("alert_reg", IDX_ALERT, 32'h0);
    $display("test alert done");
  endtask

  // ****************************************
  // Sequence, watchdog and verdict
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    foreach (samp[i]) samp[i] = 12'h000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_cells();
    t_aux();
    t_flex();
    t_alert();
    summarize();
  end

  // Cuts a hang short
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    $display("MISMATCH watchdog expected end seen hang");
    summarize();
  end
endmodule
`default_nettype wire
